// ==== hw/ccc_link_if.sv ====
// Purpose: Link between converter end and controller end
// Assumes: Both ends on the same clock
// Notes:   Request is taken when valid and ready are both high
`timescale 1ns/10ps
interface ccc_link_if;
    import ccc_pkg::*;

    logic req_valid;
    logic req_ready;
    cmd_t req_cmd;
    logic [7:0] req_addr;
    logic [7:0] req_wdata;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_last;

    modport converter (
        input req_valid, req_cmd, req_addr, req_wdata,
        output req_ready, rsp_valid, rsp_data, rsp_last
    );

    modport controller (
        output req_valid, req_cmd, req_addr, req_wdata,
        input req_ready, rsp_valid, rsp_data, rsp_last
    );

endinterface

// ==== hw/ccc_pkg.sv ====
// Purpose: Shared constants and types for the conversion check-byte link
// Assumes: One 250 MHz clock shared by both ends
// Notes:   Register offsets are byte addresses on the link
package ccc_pkg;

    // ----------------------------------------
    // Link commands
    // ----------------------------------------
    typedef enum logic [1:0] {
        CMD_MAIN_RD,
        CMD_AUX_RD,
        CMD_REG_RD,
        CMD_REG_WR
    } cmd_t;

    // ----------------------------------------
    // Converter register map
    // ----------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_IFACE = 8'h02;
    localparam logic [7:0] REG_MODE = 8'h03;
    localparam logic [7:0] REG_OFS_LO = 8'h07;
    localparam logic [7:0] REG_OFS_MID = 8'h08;
    localparam logic [7:0] REG_OFS_HI = 8'h09;
    localparam logic [7:0] REG_GAIN_LO = 8'h0A;
    localparam logic [7:0] REG_GAIN_MID = 8'h0B;
    localparam logic [7:0] REG_GAIN_HI = 8'h0C;
    localparam logic [7:0] REG_AOFS_LO = 8'h17;
    localparam logic [7:0] REG_AOFS_HI = 8'h18;
    localparam logic [7:0] REG_AGAIN_LO = 8'h19;
    localparam logic [7:0] REG_AGAIN_HI = 8'h1A;

    localparam int STATUS_EXT_BIT = 5;
    localparam int MODE_CHOP_BIT = 0;

    localparam logic [1:0] IFACE_RESET = 2'h1;
    localparam logic [23:0] OFS_RESET = 24'h00_0000;
    localparam logic [23:0] GAIN_RESET = 24'h40_0000;
    localparam logic [15:0] AOFS_RESET = 16'h0000;
    localparam logic [15:0] AGAIN_RESET = 16'h4000;
    localparam int GAIN_SHIFT = 22;
    localparam int AGAIN_SHIFT = 14;

    // ----------------------------------------
    // Check byte
    // ----------------------------------------
    localparam logic [1:0] CHK_SUM = 2'h1;
    localparam logic [1:0] CHK_CRC = 2'h2;
    localparam logic [7:0] SUM_CONST = 8'h9B;
    localparam logic [7:0] CRC_POLY = 8'h07;

    // ----------------------------------------
    // Controller register map
    // ----------------------------------------
    localparam logic [3:0] HREG_CTRL = 4'h0;
    localparam logic [3:0] HREG_CHK = 4'h1;
    localparam logic [3:0] HREG_ADDR = 4'h2;
    localparam logic [3:0] HREG_WDATA = 4'h3;
    localparam logic [3:0] HREG_RESULT = 4'h4;
    localparam logic [3:0] HREG_STATUS = 4'h5;
    localparam logic [1:0] RETRY_MAX = 2'h3;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CLK_LOSS_NS = 1000;
    localparam int CLK_LOSS_CYC = CLK_LOSS_NS * CLK_MHZ / 1000;

endpackage

// ==== hw/check_byte_gen.sv ====
// Purpose: Integrity byte over a 32-bit word, sum or CRC
// Assumes: A 24-bit word enters with a zero top byte
// Notes:   Purely combinational
`timescale 1ns/10ps
module check_byte_gen
    import ccc_pkg::*;
(
    // Word and mode
    input wire logic [31:0] data_in,
    input wire logic [1:0] mode_in,
    // Result
    output logic [7:0] check_out,
    output logic enabled_out
);

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    function automatic logic [7:0] byte_sum(input logic [31:0] d);
        byte_sum = d[31:24] + d[23:16] + d[15:8] + d[7:0] + SUM_CONST;
    endfunction

    // Leading zero byte leaves a zero-start remainder unchanged
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        crc8 = r;
    endfunction

    wire [7:0] sum_val = byte_sum(data_in);
    wire [7:0] crc_val = crc8(data_in);

    assign enabled_out = (mode_in == CHK_SUM) || (mode_in == CHK_CRC);
    assign check_out = (mode_in == CHK_CRC) ? crc_val : sum_val;

endmodule

// ==== hw/controller_end.sv ====
// Purpose: Controller end: issues reads, verifies check byte, re-reads
// Assumes: Software mirrors the converter check mode in HREG_CHK
// Notes:   Read data stands one cycle after the read strobe
`timescale 1ns/10ps
module controller_end
    import ccc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Software port
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Link
    ccc_link_if.controller link
);

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_CHECK} state_t;

    // ----------------------------------------
    // State
    // ----------------------------------------
    state_t state_q;
    cmd_t op_q;
    logic [1:0] chk_q;
    logic [7:0] addr_q;
    logic [7:0] wd_q;
    logic [31:0] result_q;
    logic done_q;
    logic err_q;
    logic [1:0] tries_q;
    logic [39:0] rx_q;
    logic [31:0] rdata_q;

    wire start = wr_in && (addr_in == HREG_CTRL) && (state_q == ST_IDLE);

    // ----------------------------------------
    // Received word split
    // ----------------------------------------
    logic [7:0] chk_calc;
    logic chk_on;
    wire is_aux = (op_q == CMD_AUX_RD);
    wire [31:0] rx_main = chk_on ? rx_q[39:8] : rx_q[31:0];
    wire [23:0] rx_aux = chk_on ? rx_q[31:8] : rx_q[23:0];
    wire [31:0] rx_data = is_aux ? {8'h00, rx_aux} : rx_main;
    wire chk_bad = chk_on && (chk_calc != rx_q[7:0]);

    check_byte_gen verify (
        .data_in(rx_data),
        .mode_in(chk_q),
        .check_out(chk_calc),
        .enabled_out(chk_on)
    );

    assign link.req_valid = (state_q == ST_SEND);
    assign link.req_cmd = op_q;
    assign link.req_addr = addr_q;
    assign link.req_wdata = wd_q;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            op_q <= CMD_MAIN_RD;
            tries_q <= 2'h0;
            rx_q <= 40'h00_0000_0000;
            result_q <= 32'h0000_0000;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        op_q <= cmd_t'(wdata_in[1:0]);
                        tries_q <= 2'h0;
                        done_q <= 1'b0;
                        err_q <= 1'b0;
                        state_q <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (link.req_ready) begin
                        if (op_q == CMD_REG_WR) begin
                            done_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end else begin
                            state_q <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    if (link.rsp_valid) begin
                        rx_q <= {rx_q[31:0], link.rsp_data};
                        if (link.rsp_last) begin
                            state_q <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (op_q == CMD_REG_RD) begin
                        result_q <= {24'h00_0000, rx_q[7:0]};
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end else if (chk_bad && (tries_q != RETRY_MAX)) begin
                        tries_q <= tries_q + 2'h1;
                        state_q <= ST_SEND;
                    end else begin
                        result_q <= rx_data;
                        err_q <= chk_bad;
                        done_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            chk_q <= IFACE_RESET;
            addr_q <= 8'h00;
            wd_q <= 8'h00;
        end else if (wr_in && (state_q == ST_IDLE)) begin
            if (addr_in == HREG_CHK) begin
                chk_q <= wdata_in[1:0];
            end
            if (addr_in == HREG_ADDR) begin
                addr_q <= wdata_in[7:0];
            end
            if (addr_in == HREG_WDATA) begin
                wd_q <= wdata_in[7:0];
            end
        end
    end

    wire busy = (state_q != ST_IDLE);
    wire [31:0] status_word = {27'h000_0000, tries_q, err_q, done_q, busy};
    wire [31:0] rd_mux = (addr_in == HREG_RESULT) ? result_q :
        (addr_in == HREG_STATUS) ? status_word :
        (addr_in == HREG_CHK) ? {30'h0000_0000, chk_q} :
        (addr_in == HREG_ADDR) ? {24'h00_0000, addr_q} :
        (addr_in == HREG_WDATA) ? {24'h00_0000, wd_q} : 32'h0000_0000;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_in) begin
            rdata_q <= rd_mux;
        end
    end

    assign rdata_out = rdata_q;

endmodule

// ==== hw/converter_end.sv ====
// Purpose: Converter output path: calibration, check byte, clock detect
// Assumes: Clock pin input is synchronous to clk_in
// Notes:   One request at a time; the link is busy while bytes stream
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

module converter_end
    import ccc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link
    ccc_link_if.converter link,
    // Filter results
    input wire logic [31:0] main_filter_in,
    input wire logic main_strobe_in,
    input wire logic [23:0] aux_filter_in,
    input wire logic aux_strobe_in,
    // Clock source
    input wire logic clock_in_pin_in,
    output logic clock_select_out,
    output logic osc_run_out,
    // Corrected results
    output logic [31:0] main_data_out,
    output logic [23:0] aux_data_out
);

    // ----------------------------------------
    // Saturation helpers
    // ----------------------------------------
    function automatic logic [31:0] sat32(input logic signed [57:0] v);
        if (v[57:31] == {27{v[57]}}) begin
            sat32 = v[31:0];
        end else begin
            sat32 = v[57] ? 32'h8000_0000 : 32'h7FFF_FFFF;
        end
    endfunction

    function automatic logic [23:0] sat24(input logic signed [41:0] v);
        if (v[41:23] == {19{v[41]}}) begin
            sat24 = v[23:0];
        end else begin
            sat24 = v[41] ? 24'h80_0000 : 24'h7F_FFFF;
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [1:0] iface_q;
    logic chop_q;
    logic [23:0] ofs_q;
    logic [23:0] gain_q;
    logic [15:0] aofs_q;
    logic [15:0] again_q;
    logic ext_q;
    logic pin_q;
    logic [7:0] silence_q;
    logic [31:0] main_q;
    logic [23:0] aux_q;
    logic [39:0] tx_q;
    logic [2:0] cnt_q;

    wire accept = link.req_valid && link.req_ready;
    wire wr_hit = accept && (link.req_cmd == CMD_REG_WR);
    wire [7:0] wa = link.req_addr;
    wire [7:0] wd = link.req_wdata;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            iface_q <= IFACE_RESET;
            chop_q <= 1'b0;
            ofs_q <= OFS_RESET;
            gain_q <= GAIN_RESET;
            aofs_q <= AOFS_RESET;
            again_q <= AGAIN_RESET;
        end else if (wr_hit) begin
            case (wa)
                REG_IFACE: iface_q <= wd[1:0];
                REG_MODE: chop_q <= wd[MODE_CHOP_BIT];
                REG_OFS_LO: ofs_q[7:0] <= wd;
                REG_OFS_MID: ofs_q[15:8] <= wd;
                REG_OFS_HI: ofs_q[23:16] <= wd;
                REG_GAIN_LO: gain_q[7:0] <= wd;
                REG_GAIN_MID: gain_q[15:8] <= wd;
                REG_GAIN_HI: gain_q[23:16] <= wd;
                REG_AOFS_LO: aofs_q[7:0] <= wd;
                REG_AOFS_HI: aofs_q[15:8] <= wd;
                REG_AGAIN_LO: again_q[7:0] <= wd;
                REG_AGAIN_HI: again_q[15:8] <= wd;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register read mux
    // ----------------------------------------
    logic [7:0] rd_val;
    always_comb begin
        case (link.req_addr)
            REG_STATUS: rd_val = 8'(ext_q) << STATUS_EXT_BIT;
            REG_IFACE: rd_val = {6'h00, iface_q};
            REG_MODE: rd_val = {7'h00, chop_q};
            REG_OFS_LO: rd_val = ofs_q[7:0];
            REG_OFS_MID: rd_val = ofs_q[15:8];
            REG_OFS_HI: rd_val = ofs_q[23:16];
            REG_GAIN_LO: rd_val = gain_q[7:0];
            REG_GAIN_MID: rd_val = gain_q[15:8];
            REG_GAIN_HI: rd_val = gain_q[23:16];
            REG_AOFS_LO: rd_val = aofs_q[7:0];
            REG_AOFS_HI: rd_val = aofs_q[15:8];
            REG_AGAIN_LO: rd_val = again_q[7:0];
            REG_AGAIN_HI: rd_val = again_q[15:8];
            default: rd_val = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Calibration datapath
    // ----------------------------------------
    // Offset is zeroed under chop rather than muxing the result
    wire [31:0] ofs_aligned = chop_q ? 32'h0000_0000 : {ofs_q, 8'h00};
    wire signed [32:0] main_diff = $signed({main_filter_in[31], main_filter_in})
        - $signed({ofs_aligned[31], ofs_aligned});
    wire signed [57:0] main_prod = main_diff * $signed({1'b0, gain_q});
    wire signed [57:0] main_scaled = main_prod >>> GAIN_SHIFT;

    wire [23:0] aofs_aligned = {aofs_q, 8'h00};
    wire signed [24:0] aux_diff = $signed({aux_filter_in[23], aux_filter_in})
        - $signed({aofs_aligned[23], aofs_aligned});
    wire signed [41:0] aux_prod = aux_diff * $signed({1'b0, again_q});
    wire signed [41:0] aux_scaled = aux_prod >>> AGAIN_SHIFT;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            main_q <= 32'h0000_0000;
            aux_q <= 24'h00_0000;
        end else begin
            if (main_strobe_in) begin
                main_q <= sat32(main_scaled);
            end
            if (aux_strobe_in) begin
                aux_q <= sat24(aux_scaled);
            end
        end
    end

    assign main_data_out = main_q;
    assign aux_data_out = aux_q;

    // ----------------------------------------
    // Check bytes
    // ----------------------------------------
    logic [7:0] chk_main;
    logic [7:0] chk_aux;
    logic chk_en;

    check_byte_gen main_chk (
        .data_in(main_q),
        .mode_in(iface_q),
        .check_out(chk_main),
        .enabled_out(chk_en)
    );

    check_byte_gen aux_chk (
        .data_in({8'h00, aux_q}),
        .mode_in(iface_q),
        .check_out(chk_aux),
        .enabled_out()
    );

    // ----------------------------------------
    // Byte streaming
    // ----------------------------------------
    assign link.req_ready = (cnt_q == 3'd0);
    assign link.rsp_valid = (cnt_q != 3'd0);
    assign link.rsp_data = tx_q[39:32];
    assign link.rsp_last = (cnt_q == 3'd1);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tx_q <= 40'h00_0000_0000;
            cnt_q <= 3'd0;
        end else if (accept) begin
            case (link.req_cmd)
                CMD_MAIN_RD: begin
                    tx_q <= {main_q, chk_main};
                    cnt_q <= chk_en ? 3'd5 : 3'd4;
                end
                CMD_AUX_RD: begin
                    tx_q <= {aux_q, chk_aux, 8'h00};
                    cnt_q <= chk_en ? 3'd4 : 3'd3;
                end
                CMD_REG_RD: begin
                    tx_q <= {rd_val, 32'h0000_0000};
                    cnt_q <= 3'd1;
                end
                default: ;
            endcase
        end else if (cnt_q != 3'd0) begin
            tx_q <= {tx_q[31:0], 8'h00};
            cnt_q <= cnt_q - 3'd1;
        end
    end

    // ----------------------------------------
    // Clock source detection
    // ----------------------------------------
    // Flag drops after a quiet spell; a stopped external clock falls back
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_q <= 1'b0;
            silence_q <= 8'h00;
            ext_q <= 1'b0;
        end else begin
            pin_q <= clock_in_pin_in;
            if (pin_q != clock_in_pin_in) begin
                silence_q <= 8'h00;
                ext_q <= 1'b1;
            end else if (silence_q == 8'(CLK_LOSS_CYC - 1)) begin
                ext_q <= 1'b0;
            end else begin
                silence_q <= silence_q + 8'h01;
            end
        end
    end

    assign clock_select_out = ext_q;
    assign osc_run_out = 1'b1;

endmodule

// ==== testbench/link_monitor.sv ====
// Purpose: Protocol checks on the link between the two ends
// Assumes: Both ends share clk_in; rst_in is synchronous, active high
// Notes:   Sees only interface signals, instantiated beside the link
`timescale 1ns/10ps
module link_monitor
    import ccc_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Request side
    input wire logic req_valid,
    input wire logic req_ready,
    input wire cmd_t req_cmd,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_wdata,
    // Response side
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_last
);
    // ----------------------------------------
    // Link properties
    // ----------------------------------------
    wire acc = req_valid && req_ready;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_RSP_START: assert property (acc && req_cmd != CMD_REG_WR |=> rsp_valid)
        else $error("read accepted without a response byte next cycle");
    AST_WR_QUIET: assert property (acc && req_cmd == CMD_REG_WR |=> !rsp_valid && req_ready)
        else $error("register write produced a response");
    AST_REG_ONE: assert property (acc && req_cmd == CMD_REG_RD |=> rsp_valid && rsp_last)
        else $error("register read was not a single byte");
    AST_MAIN_LEN: assert property (acc && req_cmd == CMD_MAIN_RD |=>
        (rsp_valid && !rsp_last)[*3] ##1 rsp_valid ##1 (!rsp_valid || rsp_last))
        else $error("main read length wrong");
    AST_AUX_LEN: assert property (acc && req_cmd == CMD_AUX_RD |=>
        (rsp_valid && !rsp_last)[*2] ##1 rsp_valid ##1 (!rsp_valid || rsp_last))
        else $error("aux read length wrong");
    AST_BUSY: assert property (rsp_valid |-> !req_ready)
        else $error("ready high while streaming");
    AST_END: assert property (rsp_last |-> rsp_valid ##1 (!rsp_valid && req_ready))
        else $error("stream did not end after last byte");
    AST_HOLD: assert property (req_valid |-> req_ready && !rsp_valid)
        else $error("request raised while a stream was running");

    COV_MAIN: cover property (acc && req_cmd == CMD_MAIN_RD);
    COV_AUX: cover property (acc && req_cmd == CMD_AUX_RD);
    COV_REG: cover property (acc && req_cmd == CMD_REG_RD);
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for converter and controller ends
// Assumes: Both ends share clk_in
// Notes:   Captured check bytes are compared with constants or values recomputed from expected words
`timescale 1ns/10ps
module testbench;
    import ccc_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic [31:0] main_filter_in = 32'h0000_0000;
    logic [23:0] aux_filter_in = 24'h00_0000;
    logic wr_in = 1'b0, rd_in = 1'b0, main_strobe_in = 1'b0, aux_strobe_in = 1'b0;
    logic clock_in_pin_in = 1'b0;
    logic [31:0] rdata_out, main_data_out, res, st;
    logic [23:0] aux_data_out;
    logic clock_select_out, osc_run_out;
    logic [7:0] rx_q[$];
    logic [31:0] vals[4] = '{32'h1234_5678, 32'h7000_0000, 32'h9000_0000, 32'h1234_5678};
    int mismatches = 0, n_tests = 0, cycles = 0;

    ccc_link_if link ();
    converter_end u_converter_end (.clk_in(clk_in), .rst_in(rst_in), .link(link),
        .main_filter_in(main_filter_in), .main_strobe_in(main_strobe_in),
        .aux_filter_in(aux_filter_in), .aux_strobe_in(aux_strobe_in),
        .clock_in_pin_in(clock_in_pin_in), .clock_select_out(clock_select_out),
        .osc_run_out(osc_run_out), .main_data_out(main_data_out), .aux_data_out(aux_data_out));
    controller_end u_controller_end (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link));
    link_monitor u_link_monitor (.clk_in(clk_in), .rst_in(rst_in), .req_valid(link.req_valid),
        .req_ready(link.req_ready), .req_cmd(link.req_cmd), .req_addr(link.req_addr),
        .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data),
        .rsp_last(link.rsp_last));

    // ----------------------------------------
    // Clock, capture, tasks
    // ----------------------------------------
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (link.rsp_valid === 1'b1) rx_q.push_back(link.rsp_data);
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    // Polls status under a bound so a stuck controller cannot hang the run
    task automatic link_op(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
        sw_wr(HREG_ADDR, {24'h00_0000, a});
        sw_wr(HREG_WDATA, {24'h00_0000, d});
        rx_q.delete();
        sw_wr(HREG_CTRL, {30'h0000_0000, op});
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 200; i++) begin
            sw_rd(HREG_STATUS, st);
            if (st[1] === 1'b1 && st[0] === 1'b0) break;
        end
        // A poll limit that runs out is a failure, not a silent fall-through
        if (st[1:0] !== 2'b10) mismatches++;
        sw_rd(HREG_RESULT, res);
    endtask
    task automatic cwr(input logic [7:0] a, input logic [7:0] d);
        link_op(CMD_REG_WR, a, d);
    endtask
    function automatic logic [7:0] sum8(input logic [31:0] w, input int n);
        logic [7:0] s;
        s = 8'h9B;
        for (int k = 0; k < n; k++) s = s + w[8*k +: 8];
        return s;
    endfunction
    function automatic logic [7:0] crc8(input logic [31:0] w, input int n);
        logic [7:0] c;
        c = 8'h00;
        for (int i = n * 8 - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    function automatic logic [31:0] corr(input logic [31:0] f, input logic [23:0] o,
        input logic [23:0] g, input logic chop);
        longint v;
        v = longint'(signed'(f)) - (chop ? 64'sh0 : (longint'(signed'(o)) <<< 8));
        v = (v * longint'(g)) >>> 22;
        if (v > 64'sh7FFF_FFFF) return 32'h7FFF_FFFF;
        if (v < -64'sh8000_0000) return 32'h8000_0000;
        return v[31:0];
    endfunction
    task automatic load_main(input logic [31:0] v);
        @(posedge clk_in);
        main_filter_in <= v;
        main_strobe_in <= 1'b1;
        @(posedge clk_in);
        main_strobe_in <= 1'b0;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        check({31'h0, osc_run_out}, 32'h1);
        check({31'h0, clock_select_out}, 32'h0);
        link_op(CMD_REG_RD, REG_OFS_LO, 8'h00);
        check(res, 32'h0000_0000);
        check(32'(rx_q.size()), 32'h1);
        link_op(CMD_REG_RD, 8'h30, 8'h00);
        check(res, 32'h0000_0000);
        $display("test reset done");
        load_main(vals[0]);
        for (int m = 0; m < 4; m++) begin
            cwr(REG_IFACE, 8'(m));
            sw_wr(HREG_CHK, 32'(m));
            link_op(CMD_MAIN_RD, 8'h00, 8'h00);
            check(res, vals[0]);
            check(32'(rx_q.size()), (m == 1 || m == 2) ? 32'h5 : 32'h4);
            if (m == 1) check(rx_q[4], 8'hAF);
            if (m == 2) check(rx_q[4], 8'h1C);
        end
        cwr(REG_IFACE, 8'h01);
        // Controller expects CRC while the converter sends a sum, so every try fails
        sw_wr(HREG_CHK, 32'h2);
        link_op(CMD_MAIN_RD, 8'h00, 8'h00);
        check(st[4:2], {RETRY_MAX, 1'b1});
        check(32'(rx_q.size()), 32'h14);
        sw_wr(HREG_CHK, 32'h1);
        $display("test check modes done");
        cwr(REG_OFS_LO, 8'h01);
        cwr(REG_OFS_MID, 8'h02);
        cwr(REG_OFS_HI, 8'h03);
        cwr(REG_GAIN_HI, 8'h80);
        for (int k = 0; k < 4; k++) begin
            cwr(REG_MODE, (k == 3) ? 8'h01 : 8'h00);
            load_main(vals[k]);
            link_op(CMD_MAIN_RD, 8'h00, 8'h00);
            check(res, corr(vals[k], 24'h03_0201, 24'h80_0000, k == 3));
            check(main_data_out, corr(vals[k], 24'h03_0201, 24'h80_0000, k == 3));
        end
        link_op(CMD_REG_RD, REG_OFS_HI, 8'h00);
        check(res, 32'h0000_0003);
        $display("test calibration done");
        cwr(REG_AOFS_LO, 8'h01);
        cwr(REG_AOFS_HI, 8'h02);
        @(posedge clk_in);
        aux_filter_in <= 24'h12_3456;
        aux_strobe_in <= 1'b1;
        @(posedge clk_in);
        aux_strobe_in <= 1'b0;
        for (int m = 1; m < 3; m++) begin
            cwr(REG_IFACE, 8'(m));
            sw_wr(HREG_CHK, 32'(m));
            link_op(CMD_AUX_RD, 8'h00, 8'h00);
            check({8'h00, res[23:0]}, 32'h0010_3356);
            check({8'h00, aux_data_out}, 32'h0010_3356);
            check(32'(rx_q.size()), 32'h4);
            check(rx_q[3], (m == 1) ? sum8(32'h0010_3356, 3) : crc8(32'h0010_3356, 3));
        end
        $display("test aux done");
        repeat (20) @(posedge clk_in) clock_in_pin_in <= ~clock_in_pin_in;
        link_op(CMD_REG_RD, REG_STATUS, 8'h00);
        check({31'h0, res[STATUS_EXT_BIT]}, 32'h1);
        check({31'h0, clock_select_out}, 32'h1);
        repeat (300) @(posedge clk_in);
        check({31'h0, clock_select_out}, 32'h0);
        $display("test clock done");
        report_and_stop();
    end
endmodule
